//--- srx_map.svh
// Purpose: Offsets, field positions, reset values and counts of the receive status block
// Assumes: Included by bare name wherever a constant is needed
// Notes:   Definitions only
// Notes on behaviour
// - Idle flag is status bit four
// - Idle needs 10 or 11 high bit times
// - Idle type clear: count from after start
// - Idle type set: count after stop bits
// - Status read then data read clears idle
// - Idle rearms only after next full flag
// - Idle flag sets once per idle period
// - Overrun bit three when data unread
// - Overrun drops new character, keeps old
// - Status read then data read clears overrun
// - Full flag zero empty, one holds character
// - Seven start samples, three per bit
// - Noise bit two on sample disagreement
// - Noise rises with the full flag
// - Full flag sets on shifter transfer
`ifndef SRX_MAP_SVH
`define SRX_MAP_SVH
`define SRX_AW            3
`define SRX_DW            16
`define SRX_OFS_STATUS    3'h0
`define SRX_OFS_DATA      3'h1
`define SRX_OFS_CTRL      3'h2
`define SRX_OFS_BAUD      3'h3
`define SRX_OFS_IRQ_STAT  3'h4
`define SRX_OFS_IRQ_MASK  3'h5
`define SRX_BIT_FULL      5
`define SRX_BIT_IDLE      4
`define SRX_BIT_OVR       3
`define SRX_BIT_NOISE     2
`define SRX_CTRL_LONG     0
`define SRX_CTRL_IDLE_TYPE 1
`define SRX_BAUD_W        13
`define SRX_BAUD_RST      13'h0082
`define SRX_RT_LAST       4'hF
`define SRX_RT_START_EVAL 4'hC
`define SRX_RT_BIT_EVAL   4'hB
`define SRX_BITS_SHORT    4'h8
`define SRX_BITS_LONG     4'h9
`define SRX_START_SAMPLES 3'h7
`define SRX_BIT_SAMPLES   3'h3
`define SRX_IDLE_SHORT    8'hA0
`define SRX_IDLE_LONG     8'hB0
`endif

//--- srx_pkg.sv
// Purpose: Types shared by the receive status block
// Assumes: Constants live in srx_map.svh
// Notes:   Types only
package srx_pkg;
   typedef enum logic [1:0] {
      SRX_S_IDLE  = 2'b00,
      SRX_S_START = 2'b01,
      SRX_S_DATA  = 2'b10,
      SRX_S_STOP  = 2'b11
   } srx_state_t;
   typedef struct packed {
      logic idle_after_stop;
      logic char_long;
   } srx_cfg_t;
   typedef struct packed {
      logic full;
      logic idle;
      logic ovr;
      logic noise;
   } srx_flags_t;
endpackage : srx_pkg

//--- srx_vote.sv
// Purpose: Majority of three samples with disagreement flag
// Assumes: Samples already captured in flip-flops
// Notes:   Pure combinational
module srx_vote (
   // Samples
   input  wire logic [2:0] samples,
   // Result
   output logic            level,
   output logic            disagree
);
   assign level    = (samples[0] & samples[1]) | (samples[0] & samples[2])
                   | (samples[1] & samples[2]);
   assign disagree = (samples != 3'h0) && (samples != 3'h7);
endmodule : srx_vote

//--- srx_top.sv
// Purpose: Serial receiver with full, idle, overrun and noise status flags
// Assumes: rx_line synchronous to clock; 16 baud ticks per bit time
// Notes:   Full, idle and overrun clear by a status read then a data read; noise clears on any data read
//
// The register offsets and the address-and-strobe port were decided locally.
`include "srx_map.svh"
module srx_top (
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   reset,
   // Register port
   input  wire logic [`SRX_AW-1:0]     addr,
   input  wire logic [`SRX_DW-1:0]     wr_data,
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   output logic      [`SRX_DW-1:0]     rd_data,
   // Serial line
   input  wire logic                   rx_line,
   // Interrupt
   output logic                        irq
);
   srx_pkg::srx_cfg_t    cfg_ff;
   srx_pkg::srx_flags_t  flg_ff, snap_ff;
   srx_pkg::srx_state_t  st_ff, nxt_st;
   logic [`SRX_BAUD_W-1:0] baud_ff, div_ff;
   logic [3:0]           rt_ff, bit_ff;
   logic [6:0]           samp_ff;
   logic [8:0]           shift_ff, data_ff;
   logic                 nacc_ff, idle_arm_ff;
   logic [7:0]           idle_cnt_ff, nxt_idle_cnt;
   logic [3:0]           irq_st_ff, irq_mask_ff;
   logic [`SRX_DW-1:0]   rd_data_ff;

   // Register decode
   wire sel_status = (addr == `SRX_OFS_STATUS);
   wire sel_data   = (addr == `SRX_OFS_DATA);
   wire rd_status  = rd_en && sel_status;
   wire rd_dreg    = rd_en && sel_data;
   wire wr_ctrl    = wr_en && (addr == `SRX_OFS_CTRL);
   wire wr_baud    = wr_en && (addr == `SRX_OFS_BAUD);
   wire wr_istat   = wr_en && (addr == `SRX_OFS_IRQ_STAT);
   wire wr_imask   = wr_en && (addr == `SRX_OFS_IRQ_MASK);

   // Baud tick divider; a zero divisor is treated as one
   // A new divisor restarts the count at once, so the old period does not linger
   wire tick = (div_ff == '0) || (div_ff == `SRX_BAUD_W'(1));
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         div_ff <= '0;
      end else if (wr_baud) begin
         div_ff <= '0;
      end else if (tick) begin
         div_ff <= baud_ff;
      end else begin
         div_ff <= div_ff - `SRX_BAUD_W'(1);
      end
   end

   // Sample points: seven in the start bit, three in every other bit
   wire start_pt = (rt_ff == 4'h3) || (rt_ff == 4'h5) || (rt_ff == 4'h7)
                 || (rt_ff == 4'h8) || (rt_ff == 4'h9) || (rt_ff == 4'hA)
                 || (rt_ff == 4'hB);
   wire bit_pt   = (rt_ff == 4'h8) || (rt_ff == 4'h9) || (rt_ff == 4'hA);
   wire take_smp = tick && (((st_ff == srx_pkg::SRX_S_START) && start_pt)
                 || ((st_ff != srx_pkg::SRX_S_START) && (st_ff != srx_pkg::SRX_S_IDLE)
                 && bit_pt));

   logic bit_level, bit_noisy, mid_level;
   srx_vote u_vote_bit (
      .samples  (samp_ff[2:0]),
      .level    (bit_level),
      .disagree (bit_noisy)
   );
   srx_vote u_vote_start (
      .samples  (samp_ff[3:1]),
      .level    (mid_level),
      .disagree ()
   );

   wire start_noisy = (samp_ff != 7'h00) && (samp_ff != 7'h7F);
   wire eval_start  = tick && (st_ff == srx_pkg::SRX_S_START)
                    && (rt_ff == `SRX_RT_START_EVAL);
   wire eval_bit    = tick && (rt_ff == `SRX_RT_BIT_EVAL)
                    && ((st_ff == srx_pkg::SRX_S_DATA) || (st_ff == srx_pkg::SRX_S_STOP));
   wire false_start = eval_start && mid_level;
   wire [3:0] nbits = cfg_ff.char_long ? `SRX_BITS_LONG : `SRX_BITS_SHORT;
   wire bit_end     = tick && (rt_ff == `SRX_RT_LAST);
   wire last_data   = (bit_ff == nbits - 4'h1);
   wire char_done   = eval_bit && (st_ff == srx_pkg::SRX_S_STOP);
   wire char_noisy  = nacc_ff || bit_noisy;

   // Character complete: load when empty, otherwise overrun
   wire load    = char_done && !flg_ff.full;
   wire ovr_evt = char_done && flg_ff.full;

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         srx_pkg::SRX_S_IDLE: begin
            if (tick && !rx_line) begin
               nxt_st = srx_pkg::SRX_S_START;
            end
         end
         srx_pkg::SRX_S_START: begin
            if (false_start) begin
               nxt_st = srx_pkg::SRX_S_IDLE;
            end else if (bit_end) begin
               nxt_st = srx_pkg::SRX_S_DATA;
            end
         end
         srx_pkg::SRX_S_DATA: begin
            if (bit_end && last_data) begin
               nxt_st = srx_pkg::SRX_S_STOP;
            end
         end
         srx_pkg::SRX_S_STOP: begin
            if (char_done) begin
               nxt_st = srx_pkg::SRX_S_IDLE;
            end
         end
         default: nxt_st = srx_pkg::SRX_S_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         st_ff <= srx_pkg::SRX_S_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Bit timing within a frame
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rt_ff  <= 4'h0;
         bit_ff <= 4'h0;
      end else if (tick) begin
         if (st_ff == srx_pkg::SRX_S_IDLE) begin
            rt_ff  <= 4'h1;
            bit_ff <= 4'h0;
         end else begin
            rt_ff <= rt_ff + 4'h1;
            if (bit_end && (st_ff == srx_pkg::SRX_S_DATA)) begin
               bit_ff <= bit_ff + 4'h1;
            end
         end
      end
   end

   // Samples, data shifter and noise accumulator
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         samp_ff  <= 7'h00;
         shift_ff <= 9'h000;
         nacc_ff  <= 1'b0;
      end else begin
         if (take_smp) begin
            samp_ff <= {samp_ff[5:0], rx_line};
         end
         if (st_ff == srx_pkg::SRX_S_IDLE) begin
            nacc_ff <= 1'b0;
         end else if (eval_start) begin
            nacc_ff <= start_noisy;
         end else if (eval_bit && (st_ff == srx_pkg::SRX_S_DATA)) begin
            nacc_ff  <= nacc_ff | bit_noisy;
            shift_ff <= cfg_ff.char_long ? {bit_level, shift_ff[8:1]}
                                         : {1'b0, bit_level, shift_ff[7:1]};
         end
      end
   end

   // Samples taken since the last vote; kept for the sample-count checks only
   logic [2:0] smp_cnt_ff;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         smp_cnt_ff <= 3'h0;
      end else if (eval_start || eval_bit || (st_ff == srx_pkg::SRX_S_IDLE)) begin
         smp_cnt_ff <= 3'h0;
      end else if (take_smp) begin
         smp_cnt_ff <= smp_cnt_ff + 3'h1;
      end
   end

   // Idle detection on baud ticks; idle type set counts only in the idle state
   wire counting  = cfg_ff.idle_after_stop ? (st_ff == srx_pkg::SRX_S_IDLE)
                  : (st_ff != srx_pkg::SRX_S_START);
   wire [7:0] idle_thr = cfg_ff.char_long ? `SRX_IDLE_LONG : `SRX_IDLE_SHORT;
   wire idle_set  = tick && counting && rx_line && idle_arm_ff
                  && (idle_cnt_ff == idle_thr - 8'h01);

   always_comb begin
      nxt_idle_cnt = idle_cnt_ff;
      if (!counting || (tick && !rx_line)) begin
         nxt_idle_cnt = 8'h00;
      end else if (tick && (idle_cnt_ff != idle_thr)) begin
         nxt_idle_cnt = idle_cnt_ff + 8'h01;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         idle_cnt_ff <= 8'h00;
         idle_arm_ff <= 1'b0;
      end else begin
         idle_cnt_ff <= nxt_idle_cnt;
         if (load) begin
            idle_arm_ff <= 1'b1;
         end else if (idle_set) begin
            idle_arm_ff <= 1'b0;
         end
      end
   end

   // Status flags; a set in the same cycle as the clear wins
   wire clr_seq = rd_dreg;
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         flg_ff  <= '0;
         snap_ff <= '0;
         data_ff <= 9'h000;
      end else begin
         if (rd_status) begin
            snap_ff <= flg_ff;
         end else if (clr_seq) begin
            snap_ff <= '0;
         end
         if (load) begin
            data_ff     <= shift_ff;
            flg_ff.full <= 1'b1;
            flg_ff.noise <= char_noisy;
         end else if (clr_seq && snap_ff.full) begin
            flg_ff.full  <= 1'b0;
            flg_ff.noise <= 1'b0;
         end else if (clr_seq) begin
            flg_ff.noise <= 1'b0;
         end
         if (ovr_evt) begin
            flg_ff.ovr <= 1'b1;
         end else if (clr_seq && snap_ff.ovr) begin
            flg_ff.ovr <= 1'b0;
         end
         if (idle_set) begin
            flg_ff.idle <= 1'b1;
         end else if (clr_seq && snap_ff.idle) begin
            flg_ff.idle <= 1'b0;
         end
      end
   end

   // Control, baud and interrupt registers
   wire [3:0] irq_evt = {load, idle_set, ovr_evt, load && char_noisy};
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         cfg_ff      <= '0;
         baud_ff     <= `SRX_BAUD_RST;
         irq_st_ff   <= 4'h0;
         irq_mask_ff <= 4'h0;
      end else begin
         if (wr_ctrl) begin
            cfg_ff.char_long       <= wr_data[`SRX_CTRL_LONG];
            cfg_ff.idle_after_stop <= wr_data[`SRX_CTRL_IDLE_TYPE];
         end
         if (wr_baud) begin
            baud_ff <= wr_data[`SRX_BAUD_W-1:0];
         end
         if (wr_imask) begin
            irq_mask_ff <= wr_data[3:0];
         end
         irq_st_ff <= irq_evt | (irq_st_ff & ~(wr_istat ? wr_data[3:0] : 4'h0));
      end
   end

   assign irq = |(irq_st_ff & irq_mask_ff);

   // Read data, valid in the cycle after the strobe only
   logic [`SRX_DW-1:0] rd_mux;
   always_comb begin
      rd_mux = '0;
      case (addr)
         `SRX_OFS_STATUS: begin
            rd_mux[`SRX_BIT_FULL]  = flg_ff.full;
            rd_mux[`SRX_BIT_IDLE]  = flg_ff.idle;
            rd_mux[`SRX_BIT_OVR]   = flg_ff.ovr;
            rd_mux[`SRX_BIT_NOISE] = flg_ff.noise;
         end
         `SRX_OFS_DATA:      rd_mux[8:0] = data_ff;
         `SRX_OFS_CTRL:      rd_mux[1:0] = cfg_ff;
         `SRX_OFS_BAUD:      rd_mux[`SRX_BAUD_W-1:0] = baud_ff;
         `SRX_OFS_IRQ_STAT:  rd_mux[3:0] = irq_st_ff;
         `SRX_OFS_IRQ_MASK:  rd_mux[3:0] = irq_mask_ff;
         default:            rd_mux = '0;
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rd_data_ff <= '0;
      end else begin
         rd_data_ff <= rd_en ? rd_mux : '0;
      end
   end
   assign rd_data = rd_data_ff;

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   a_full_on_load: assert property (load |=> flg_ff.full)
      else $error("full flag not set after load");
   a_noise_with_full: assert property ($rose(flg_ff.noise) |-> $rose(flg_ff.full))
      else $error("noise rose without full");
   a_ovr_sets: assert property (ovr_evt |=> flg_ff.ovr)
      else $error("overrun not flagged");
   a_ovr_keeps_data: assert property (ovr_evt |=> $stable(data_ff))
      else $error("overrun changed data");
   a_idle_once: assert property (idle_set |=> !idle_arm_ff ##1 !idle_set)
      else $error("idle set twice");
   a_idle_needs_arm: assert property ($rose(flg_ff.idle) |-> $past(idle_arm_ff))
      else $error("idle set without new character");
   a_idle_threshold: assert property
      (idle_set |-> idle_cnt_ff == (cfg_ff.char_long ? `SRX_IDLE_LONG : `SRX_IDLE_SHORT) - 8'h01)
      else $error("idle threshold wrong");
   a_idle_type_hold: assert property
      ((cfg_ff.idle_after_stop && st_ff == srx_pkg::SRX_S_DATA) |-> idle_cnt_ff == 8'h00)
      else $error("idle counted during frame");
   a_idle_clear_seq: assert property
      ((clr_seq && snap_ff.idle && !idle_set) |=> !flg_ff.idle)
      else $error("idle not cleared");
   a_full_encoding: assert property
      (rd_status |=> rd_data[`SRX_BIT_FULL] == $past(flg_ff.full))
      else $error("full bit misreported");
   a_start_seven: assert property (eval_start |-> smp_cnt_ff == `SRX_START_SAMPLES)
      else $error("start bit sample count wrong");
   a_bit_three: assert property (eval_bit |-> smp_cnt_ff == `SRX_BIT_SAMPLES)
      else $error("bit sample count wrong");
   a_ovr_clear_seq: assert property
      ((clr_seq && snap_ff.ovr && !ovr_evt) |=> !flg_ff.ovr)
      else $error("overrun not cleared");
   a_full_clear_seq: assert property
      ((clr_seq && snap_ff.full && !load) |=> !flg_ff.full)
      else $error("full flag not cleared");
   a_noise_accum: assert property
      ((eval_bit && bit_noisy && st_ff == srx_pkg::SRX_S_DATA) |=> nacc_ff)
      else $error("noisy bit not accumulated");

   c_char_loaded: cover property (load);
   c_overrun: cover property (ovr_evt);
   c_idle_seen: cover property (idle_set);
   c_noisy_char: cover property (load && char_noisy);
   c_idle_after_stop: cover property (idle_set && cfg_ff.idle_after_stop);
endmodule : srx_top

//--- srx_tx_model.sv
// Purpose: Remote serial transmitter that drives the receive line
// Assumes: One bit time is BIT_CLKS clocks; one stop bit
// Notes:   Optional one-clock glitch in data bit 2 to provoke noise
module srx_tx_model #(
   parameter int BIT_CLKS = 16
) (
   // Clock
   input  wire logic       clock,
   // Request
   input  wire logic       go,
   input  wire logic [8:0] data_in,
   input  wire logic       long_char,
   input  wire logic       glitch,
   // Line
   output logic            line,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      line = 1'b1;
      busy = 1'b0;
   end

   // A single short glitch flips one sample only, so the majority still wins
   task automatic send_bit(input logic v, input logic g);
      line <= v;
      repeat (9) @(posedge clock);
      if (g) begin
         line <= ~v;
      end
      @(posedge clock);
      line <= v;
      repeat (BIT_CLKS - 10) @(posedge clock);
   endtask : send_bit

   // Line rests high between frames, as a pulled-up idle line does
   always begin
      @(posedge clock);
      if (go) begin
         busy <= 1'b1;
         send_bit(1'b0, 1'b0);
         for (int i = 0; i < (long_char ? 9 : 8); i++) begin
            send_bit(data_in[i], glitch && i == 2);
         end
         send_bit(1'b1, 1'b0);
         busy <= 1'b0;
      end
   end
endmodule : srx_tx_model

//--- tb.sv
// Purpose: Self-checking bench for the receive status block
// Assumes: Baud divisor 1 gives 16 clocks per bit
// Notes:   Status compared whole, so stray flags show up
`include "srx_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] FUL = 16'h0001 << `SRX_BIT_FULL;
   localparam logic [15:0] IDL = 16'h0001 << `SRX_BIT_IDLE;
   localparam logic [15:0] OVR = 16'h0001 << `SRX_BIT_OVR;
   localparam logic [15:0] NOI = 16'h0001 << `SRX_BIT_NOISE;
   logic              clock   = 1'b0;
   logic              reset   = 1'b1;
   logic [`SRX_AW-1:0] addr   = '0;
   logic [15:0]       wr_data = 16'h0000;
   logic              wr_en   = 1'b0;
   logic              rd_en   = 1'b0;
   logic [15:0]       rd_data;
   logic              rx_line;
   logic              irq;
   logic              go      = 1'b0;
   logic [8:0]        tx_data = 9'h000;
   logic              tx_long = 1'b0;
   logic              glitch  = 1'b0;
   logic              tx_busy;
   logic [15:0]       r;
   int                miscompares = 0;
   int                checks_done = 0;

   srx_top dut_u (.clock(clock), .reset(reset), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_line(rx_line), .irq(irq));
   srx_tx_model tx_u (.clock(clock), .go(go), .data_in(tx_data), .long_char(tx_long),
      .glitch(glitch), .line(rx_line), .busy(tx_busy));

   always #25 clock = ~clock;

   task automatic summarize();
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge clock);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [2:0] a);
      @(posedge clock);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 r = rd_data;
   endtask : rd

   task automatic rdc(input logic [2:0] a, input logic [15:0] e);
      rd(a);
      chk(r, e);
   endtask : rdc

   task automatic send(input logic [8:0] d, input logic g, input logic l);
      int n;
      n = 0;
      @(posedge clock);
      go      <= 1'b1;
      tx_data <= d;
      glitch  <= g;
      tx_long <= l;
      @(posedge clock);
      go <= 1'b0;
      @(posedge clock);
      while (tx_busy === 1'b1 && n < 400) begin
         @(posedge clock);
         n++;
      end
      if (n >= 400) begin
         miscompares++;
         summarize();
      end
   endtask : send

   // Lets idle set, then runs the clear sequence so the next test starts clean
   task automatic drain();
      repeat (220) @(posedge clock);
      rd(`SRX_OFS_STATUS);
      rd(`SRX_OFS_DATA);
   endtask : drain

   task automatic t_reset();
      rdc(`SRX_OFS_STATUS, 16'h0000);
      rdc(`SRX_OFS_CTRL, 16'h0000);
      rdc(`SRX_OFS_BAUD, {3'h0, `SRX_BAUD_RST});
      chk({15'h0000, irq}, 16'h0000);
      wr(3'h6, 16'hFFFF);
      rdc(3'h6, 16'h0000);
      wr(`SRX_OFS_BAUD, 16'h0001);
   endtask : t_reset

   task automatic t_basic();
      send(9'h0A5, 1'b0, 1'b0);
      rdc(`SRX_OFS_STATUS, FUL);
      rdc(`SRX_OFS_DATA, 16'h00A5);
      rdc(`SRX_OFS_STATUS, 16'h0000);
      drain();
   endtask : t_basic

   // Status checked at a point where idle type and length separate the outcome
   task automatic idle_case(input logic [15:0] c, input logic [8:0] d, input int a,
                            input logic [15:0] ea, input int b);
      wr(`SRX_OFS_CTRL, c);
      send(d, 1'b0, c[`SRX_CTRL_LONG]);
      repeat (a) @(posedge clock);
      rdc(`SRX_OFS_STATUS, ea);
      repeat (b) @(posedge clock);
      rdc(`SRX_OFS_STATUS, FUL | IDL);
      rdc(`SRX_OFS_DATA, {7'h00, d});
      rdc(`SRX_OFS_STATUS, 16'h0000);
      repeat (200) @(posedge clock);
      rdc(`SRX_OFS_STATUS, 16'h0000);
   endtask : idle_case

   task automatic t_noise();
      send(9'h05A, 1'b1, 1'b0);
      rdc(`SRX_OFS_STATUS, FUL | NOI);
      rdc(`SRX_OFS_DATA, 16'h005A);
      rdc(`SRX_OFS_STATUS, 16'h0000);
      drain();
   endtask : t_noise

   task automatic t_overrun();
      send(9'h011, 1'b0, 1'b0);
      send(9'h022, 1'b1, 1'b0);
      rdc(`SRX_OFS_STATUS, FUL | OVR);
      rdc(`SRX_OFS_DATA, 16'h0011);
      rdc(`SRX_OFS_STATUS, 16'h0000);
      drain();
   endtask : t_overrun

   task automatic t_irq();
      wr(`SRX_OFS_IRQ_STAT, 16'h000F);
      rdc(`SRX_OFS_IRQ_STAT, 16'h0000);
      send(9'h033, 1'b0, 1'b0);
      rdc(`SRX_OFS_IRQ_STAT, 16'h0008);
      chk({15'h0000, irq}, 16'h0000);
      wr(`SRX_OFS_IRQ_MASK, 16'h0008);
      chk({15'h0000, irq}, 16'h0001);
      wr(`SRX_OFS_IRQ_STAT, 16'h0008);
      chk({15'h0000, irq}, 16'h0000);
   endtask : t_irq

   initial begin
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      t_reset();
      t_basic();
      idle_case(16'h0000, 9'h0FF, 40, FUL | IDL, 0);
      idle_case(16'h0002, 9'h0FF, 146, FUL, 20);
      idle_case(16'h0003, 9'h1FF, 162, FUL, 20);
      wr(`SRX_OFS_CTRL, 16'h0000);
      t_noise();
      t_overrun();
      t_irq();
      summarize();
   end

   // Whole run needs about 3000 clocks
   initial begin
      repeat (20000) @(posedge clock);
      miscompares++;
      summarize();
   end
endmodule : tb
